// [sdrtc_cal_regs.sv]
`timescale 1ns/100ps
`include "sdrtc_regs.svh"

// Functional notes
// - The two-bit predivide field divides the lane PLL reference before the detector.
// - A zero-to-one write on the start bit launches one calibration, a level launches none.
// - Override bit 4 clear selects automatic calibration, set forces bits 3 to 1 as value.
// - The calibrated code reads back from a read-only register with the top five bits zero.
module sdrtc_cal_regs
	import sdrtc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [9:0] i_reg_addr,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_rd,
	input  wire logic       i_ref_clk,
	input  wire logic [2:0] i_cal_code,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	output logic            o_pfd_ref,
	output logic            o_cal_start,
	output logic            o_term_override_en,
	output logic      [2:0] o_term_override_val
);

	logic [1:0] predivide_q;
	logic       start_q;
	logic [7:0] override_q;
	logic [2:0] code_q;
	logic       wr_prediv;
	logic       wr_ctrl;
	logic       wr_ovr;
	logic [7:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// write decode
	assign wr_prediv = i_reg_wr && (i_reg_addr == `SDRTC_ADDR_PREDIV);
	assign wr_ctrl   = i_reg_wr && (i_reg_addr == `SDRTC_ADDR_CAL_CTRL);
	assign wr_ovr    = i_reg_wr && (i_reg_addr == `SDRTC_ADDR_OVERRIDE);

	// predivide field, upper bits are not stored
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			predivide_q <= `SDRTC_RST_PREDIV;
		else if (wr_prediv)
			predivide_q <= i_reg_wdata[`SDRTC_PREDIV_MSB:`SDRTC_PREDIV_LSB];
	end

	// calibration start bit and launch pulse on its rising edge
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			start_q     <= 1'b0;
			o_cal_start <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				start_q <= i_reg_wdata[`SDRTC_START_BIT];
			o_cal_start <= wr_ctrl && i_reg_wdata[`SDRTC_START_BIT] && !start_q;
		end
	end

	// override register, fields fed straight out
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			override_q <= `SDRTC_RST_BYTE;
		else if (wr_ovr)
			override_q <= i_reg_wdata;
	end

	assign o_term_override_en  = override_q[`SDRTC_OVR_EN_BIT];
	assign o_term_override_val = override_q[`SDRTC_OVR_VAL_MSB:`SDRTC_OVR_VAL_LSB];

	// capture of the code from the calibration engine
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			code_q <= `SDRTC_RST_CODE;
		else
			code_q <= i_cal_code;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux, unmapped addresses and reserved bits outside the override register read zero
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (i_reg_addr)
			`SDRTC_ADDR_PREDIV:   rd_mux = {6'h00, predivide_q};
			`SDRTC_ADDR_CAL_CTRL: rd_mux = {7'h00, start_q};
			`SDRTC_ADDR_OVERRIDE: rd_mux = override_q;
			`SDRTC_ADDR_CAL_CODE: rd_mux = {5'h00, code_q};
			default:              rd_mux = 8'h00;
		endcase
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
				o_reg_rdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference predivider
	sdrtc_ref_predivider u_prediv
	(
		.i_clk          (i_clk),
		.i_rst_n        (i_rst_n),
		.i_ref_clk      (i_ref_clk),
		.i_divide_ratio (predivide_q),
		.o_pfd_ref      (o_pfd_ref)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// start bit written low, written high, and written high over a stored low
	sequence s_start_low;
		wr_ctrl && !i_reg_wdata[`SDRTC_START_BIT];
	endsequence

	sequence s_start_high;
		wr_ctrl && i_reg_wdata[`SDRTC_START_BIT];
	endsequence

	sequence s_start_rise;
		!start_q ##0 s_start_high;
	endsequence

	// clear, one idle cycle, then set: the way software re-arms a launch
	sequence s_start_rearm;
		s_start_low ##1 !i_reg_wr ##1 s_start_high;
	endsequence

	property p_start_edge;
		s_start_rise |=> o_cal_start ##1 !o_cal_start;
	endproperty
	a_start_edge: assert property (p_start_edge)
		else $error("rising start bit did not give one launch pulse");

	property p_start_rearm;
		s_start_rearm |=> o_cal_start;
	endproperty
	a_start_rearm: assert property (p_start_rearm)
		else $error("start bit cleared and set again did not launch");

	property p_start_quiet;
		!(wr_ctrl && i_reg_wdata[`SDRTC_START_BIT] && !start_q) |=> !o_cal_start;
	endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("launch pulse without a rising start bit");

	property p_start_level;
		start_q ##0 s_start_high |=> !o_cal_start;
	endproperty
	a_start_level: assert property (p_start_level)
		else $error("repeated start level launched calibration");

	property p_override_fields;
		wr_ovr |=> (o_term_override_en == $past(i_reg_wdata[4]))
			&& (o_term_override_val == $past(i_reg_wdata[3:1]));
	endproperty
	a_override_fields: assert property (p_override_fields)
		else $error("override fields do not match written value");

	// stored fields move only on a write to their own offset
	property p_prediv_store;
		wr_prediv |=> (predivide_q == $past(i_reg_wdata[1:0]));
	endproperty
	a_prediv_store: assert property (p_prediv_store)
		else $error("predivide field does not match written value");

	property p_prediv_hold;
		!wr_prediv |=> $stable(predivide_q);
	endproperty
	a_prediv_hold: assert property (p_prediv_hold)
		else $error("predivide field moved without a write");

	property p_override_hold;
		!wr_ovr |=> $stable(override_q);
	endproperty
	a_override_hold: assert property (p_override_hold)
		else $error("override register moved without a write");

	// read answer comes exactly one cycle after each strobe
	property p_read_answer;
		i_reg_rd |=> o_reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read strobe gave no answer");

	property p_read_idle;
		!i_reg_rd |=> !o_reg_rvalid;
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read answer without a strobe");

	property p_code_readback;
		i_reg_rd && (i_reg_addr == `SDRTC_ADDR_CAL_CODE) ##0 $past(i_rst_n)
			|=> o_reg_rvalid && (o_reg_rdata == {5'h00, $past(i_cal_code, 2)});
	endproperty
	a_code_readback: assert property (p_code_readback)
		else $error("calibration code readback wrong");

endmodule

// [sdrtc_cal_regs_tb_top.sv]
`timescale 1ns/100ps
`include "sdrtc_regs.svh"

module sdrtc_cal_regs_tb_top
	import sdrtc_pkg::*;
;
	logic       i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_ref_clk;
	logic       o_reg_rvalid, o_pfd_ref, o_cal_start, o_term_override_en;
	logic [9:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata;
	logic [2:0] i_cal_code, o_term_override_val, ref_cnt;
	int         errors, check_count, cyc;

	sdrtc_cal_regs uut
	(
		.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
		.i_ref_clk, .i_cal_code, .o_reg_rdata, .o_reg_rvalid, .o_pfd_ref,
		.o_cal_start, .o_term_override_en, .o_term_override_val
	);

	////////////////////////////////////////////////////////////////////////
	// clock, slow reference (period of 8 cycles) and hang guard
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ref_cnt <= 3'h0;
			i_ref_clk <= 1'b0;
		end
		else
		begin
			ref_cnt <= ref_cnt + 3'h1;
			i_ref_clk <= ref_cnt[2];
		end
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared compare, bus cycles and verdict
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		#1;
	endtask

	task rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1;
		chk("rvalid", {7'h00, o_reg_rvalid}, 8'h01);
		chk("rdata", o_reg_rdata, exp);
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_reset;
		rd(`SDRTC_ADDR_PREDIV, 8'h00);
		rd(`SDRTC_ADDR_CAL_CTRL, 8'h00);
		rd(`SDRTC_ADDR_OVERRIDE, 8'h00);
		rd(`SDRTC_ADDR_CAL_CODE, 8'h00);
		rd(10'h3ff, 8'h00);
		chk("start_idle", {7'h00, o_cal_start}, 8'h00);
		chk("ovr_idle", {4'h0, o_term_override_en, o_term_override_val}, 8'h00);
		$display("test reset done");
	endtask

	task t_prediv;
		int          n;
		logic        last;
		logic [7:0]  exp;
		for (int k = 0; k < 4; k++)
		begin
			wr(`SDRTC_ADDR_PREDIV, {6'h3f, k[1:0]});
			rd(`SDRTC_ADDR_PREDIV, {6'h00, k[1:0]});
			repeat (16) @(posedge i_clk);
			#1;
			n = 0;
			last = o_pfd_ref;
			repeat (64)
			begin
				@(posedge i_clk);
				#1;
				if (o_pfd_ref !== last)
					n++;
				last = o_pfd_ref;
			end
			exp = (k[1:0] == SDRTC_DIV1) ? 8'h10 : (k[1:0] == SDRTC_DIV2) ? 8'h08 : 8'h04;
			chk("pfd_toggles", n[7:0], exp);
		end
		$display("test predivider done");
	endtask

	task t_start;
		wr(`SDRTC_ADDR_CAL_CTRL, 8'hff);
		chk("start_pulse", {7'h00, o_cal_start}, 8'h01);
		@(posedge i_clk);
		#1;
		chk("start_end", {7'h00, o_cal_start}, 8'h00);
		rd(`SDRTC_ADDR_CAL_CTRL, 8'h01);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h01);
		chk("start_level", {7'h00, o_cal_start}, 8'h00);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h00);
		chk("start_clear", {7'h00, o_cal_start}, 8'h00);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h01);
		chk("start_again", {7'h00, o_cal_start}, 8'h01);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h00);
		$display("test calibration start done");
	endtask

	task t_mid_reset;
		wr(`SDRTC_ADDR_PREDIV, 8'h02);
		wr(`SDRTC_ADDR_OVERRIDE, 8'h1e);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h01);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h01);
		chk("start_after_reset", {7'h00, o_cal_start}, 8'h01);
		wr(`SDRTC_ADDR_CAL_CTRL, 8'h00);
		$display("test mid-run reset done");
	endtask

	task t_override;
		for (int v = 0; v < 8; v++)
		begin
			wr(`SDRTC_ADDR_OVERRIDE, {4'hf, v[2:0], 1'b1});
			chk("ovr_en", {7'h00, o_term_override_en}, 8'h01);
			chk("ovr_val", {5'h00, o_term_override_val}, {5'h00, v[2:0]});
			rd(`SDRTC_ADDR_OVERRIDE, {4'hf, v[2:0], 1'b1});
			wr(`SDRTC_ADDR_OVERRIDE, {4'he, v[2:0], 1'b1});
			chk("ovr_auto", {7'h00, o_term_override_en}, 8'h00);
		end
		$display("test override done");
	endtask

	task t_code;
		for (int v = 0; v < 8; v++)
		begin
			@(posedge i_clk);
			i_cal_code <= v[2:0];
			rd(`SDRTC_ADDR_CAL_CODE, {5'h00, v[2:0]});
		end
		wr(`SDRTC_ADDR_CAL_CODE, 8'h00);
		rd(`SDRTC_ADDR_CAL_CODE, 8'h07);
		$display("test calibration code done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		i_rst_n = 1'b0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 10'h000;
		i_reg_wdata = 8'h00;
		i_cal_code = 3'h0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_prediv();
		t_start();
		t_override();
		t_mid_reset();
		t_code();
		stop_test();
	end
endmodule

// [sdrtc_pkg.sv]
package sdrtc_pkg;

	// predivide ratio encodings of the two-bit field
	typedef enum logic [1:0]
	{
		SDRTC_DIV1  = 2'h0,
		SDRTC_DIV2  = 2'h1,
		SDRTC_DIV4  = 2'h2,
		SDRTC_DIVRS = 2'h3
	} sdrtc_ratio_type;

endpackage

// [sdrtc_ref_predivider.sv]
`timescale 1ns/100ps
`include "sdrtc_regs.svh"

module sdrtc_ref_predivider
	import sdrtc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ref_clk,
	input  wire logic [1:0] i_divide_ratio,
	output logic            o_pfd_ref
);

	logic            ref_q;
	logic            ref_rise;
	logic            cnt_q;
	sdrtc_ratio_type ratio;

	////////////////////////////////////////////////////////////////////////////////
	// edge detect on the sampled reference
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ref_q <= 1'b0;
		else
			ref_q <= i_ref_clk;
	end

	assign ref_rise = i_ref_clk & ~ref_q;
	assign ratio    = sdrtc_ratio_type'(i_divide_ratio);

	// divided reference toward the phase-frequency detector
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			cnt_q     <= 1'b0;
			o_pfd_ref <= 1'b0;
		end
		else
		begin
			unique case (ratio)
				SDRTC_DIV1:
				begin
					cnt_q     <= 1'b0;
					o_pfd_ref <= i_ref_clk;
				end
				SDRTC_DIV2:
				begin
					cnt_q <= 1'b0;
					if (ref_rise)
						o_pfd_ref <= ~o_pfd_ref;
				end
				default:
				begin
					// divide by four; the spare code behaves the same
					if (ref_rise)
					begin
						cnt_q <= ~cnt_q;
						if (cnt_q)
							o_pfd_ref <= ~o_pfd_ref;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_div1_follow;
		(ratio == SDRTC_DIV1) |=> (o_pfd_ref == $past(i_ref_clk));
	endproperty
	a_div1_follow: assert property (p_div1_follow)
		else $error("divide by one output does not follow reference");

	property p_div2_toggle;
		(ratio == SDRTC_DIV2) && ref_rise |=> (o_pfd_ref != $past(o_pfd_ref));
	endproperty
	a_div2_toggle: assert property (p_div2_toggle)
		else $error("divide by two output missed a toggle");

	property p_hold_no_edge;
		(ratio != SDRTC_DIV1) && !ref_rise |=> $stable(o_pfd_ref);
	endproperty
	a_hold_no_edge: assert property (p_hold_no_edge)
		else $error("divided output moved without reference edge");

endmodule

// [sdrtc_regs.svh]
`ifndef SDRTC_REGS_SVH
`define SDRTC_REGS_SVH

// register offsets on the configuration port
`define SDRTC_ADDR_PREDIV       10'h289
`define SDRTC_ADDR_CAL_CTRL     10'h2a7
`define SDRTC_ADDR_OVERRIDE     10'h2a8
`define SDRTC_ADDR_CAL_CODE     10'h2ac

// reset values, zero for every register
`define SDRTC_RST_BYTE          8'h00
`define SDRTC_RST_PREDIV        2'h0
`define SDRTC_RST_CODE          3'h0

// field positions
`define SDRTC_PREDIV_MSB        1
`define SDRTC_PREDIV_LSB        0
`define SDRTC_START_BIT         0
`define SDRTC_OVR_EN_BIT        4
`define SDRTC_OVR_VAL_MSB       3
`define SDRTC_OVR_VAL_LSB       1
`define SDRTC_CODE_MSB          2
`define SDRTC_CODE_LSB          0

`endif
